//--- logic/obs_sel_if.sv
/*
 * Carrier between the pin mux top and its observation selector.
 * Assumes both ends run on the same clock; the selector is purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
interface obs_sel_if;
    import pin_mux_pkg::*;
    logic [SEL_W-1:0] sel;
    logic test_bit;
    logic [OBS_W-1:0] obs;
    logic picked;
    modport owner (output sel, output test_bit, output obs, input picked);
    modport chooser (input sel, input test_bit, input obs, output picked);
endinterface : obs_sel_if
`default_nettype wire

//--- logic/obs_selector.sv
/*
 * Picks one observation signal by its five-bit select code.
 * Assumes the observation vector is already on the local clock; unused codes give zero.
 */
`timescale 1ns/1ps
`default_nettype none
module obs_selector (
    obs_sel_if.chooser bus
);
    import pin_mux_pkg::*;

    always_comb begin
        if (bus.sel == SEL_TEST_DATA) begin
            bus.picked = bus.test_bit; // [R7]
        end else if (bus.sel == 5'h03 || bus.sel == 5'h07 ||
                     (bus.sel >= SEL_UNUSED_FIRST && bus.sel <= SEL_UNUSED_LAST)) begin
            bus.picked = 1'b0;
        end else begin
            bus.picked = bus.obs[bus.sel]; // [R6] [R8] [R9] [R10]
        end
    end
endmodule : obs_selector
`default_nettype wire

//--- logic/pin_mux_pkg.sv
/*
 * Shared constants for the observation pin multiplexer and its register port:
 * register offsets, field positions, reset values, serial frame layout and select codes.
 * Assumes a 24-bit register data word and a 6-bit register address in each frame.
 */
package pin_mux_pkg;
    localparam int DATA_W = 24;
    localparam int ADDR_W = 6;
    localparam int HDR_BITS = 1 + ADDR_W;
    localparam int FRAME_BITS = HDR_BITS + DATA_W;
    localparam int CNT_W = 6;
    localparam int SEL_W = 5;
    localparam int OBS_W = 32;
    localparam int RATIO_W = 14;
    localparam int PINSEL_W = 10;

    // register offsets
    localparam logic [ADDR_W-1:0] EXACT_FREQUENCY_RATIO_OFS = 6'h0C;
    localparam logic [ADDR_W-1:0] OUTPUT_PIN_SELECT_CONTROL_OFS = 6'h0F;

    // reset values
    localparam logic [RATIO_W-1:0] RATIO_RST = 14'h0000;
    localparam logic [PINSEL_W-1:0] PINSEL_RST = 10'h001;

    // output_pin_select_control fields
    localparam int SIGNAL_SELECT_LSB = 0;
    localparam int TEST_DATA_BIT = 5;
    localparam int AUTOMUX_INHIBIT_BIT = 6;
    localparam int PIN_DRIVER_ALWAYS_ON_BIT = 7;
    localparam int PULLUP_TRANSISTOR_OFF_BIT = 8;
    localparam int PULLDOWN_TRANSISTOR_OFF_BIT = 9;

    // correction_ratio values below this keep exact-frequency mode off
    localparam logic [RATIO_W-1:0] RATIO_MIN_ACTIVE = 14'h0002;

    // observation select codes
    localparam logic [SEL_W-1:0] SEL_TEST_DATA = 5'h00;
    localparam logic [SEL_W-1:0] SEL_LOCK_DETECT = 5'h01;
    localparam logic [SEL_W-1:0] SEL_LOCK_WINDOW = 5'h02;
    localparam logic [SEL_W-1:0] SEL_RING_OSC = 5'h04;
    localparam logic [SEL_W-1:0] SEL_CSP_PULLUP = 5'h05;
    localparam logic [SEL_W-1:0] SEL_CSP_PULLDOWN = 5'h06;
    localparam logic [SEL_W-1:0] SEL_REF_BUFFER = 5'h08;
    localparam logic [SEL_W-1:0] SEL_REF_DIVIDER = 5'h09;
    localparam logic [SEL_W-1:0] SEL_OUT_DIVIDER = 5'h0A;
    localparam logic [SEL_W-1:0] SEL_MOD_CLOCK = 5'h0B;
    localparam logic [SEL_W-1:0] SEL_AUX_CLOCK = 5'h0C;
    localparam logic [SEL_W-1:0] SEL_AUX_SERIAL_CLOCK = 5'h0D;
    localparam logic [SEL_W-1:0] SEL_AUX_SERIAL_ENABLE = 5'h0E;
    localparam logic [SEL_W-1:0] SEL_AUX_SERIAL_DATA = 5'h0F;
    localparam logic [SEL_W-1:0] SEL_PHASE_DETECTOR_DN = 5'h10;
    localparam logic [SEL_W-1:0] SEL_PHASE_DETECTOR_UP = 5'h11;
    localparam logic [SEL_W-1:0] SEL_MOD_CLOCK_DELAY = 5'h12;
    localparam logic [SEL_W-1:0] SEL_CORE_CLOCK = 5'h13;
    localparam logic [SEL_W-1:0] SEL_STROBE_FIRST = 5'h14;
    localparam logic [SEL_W-1:0] SEL_LATCH_ENABLE = 5'h17;
    localparam logic [SEL_W-1:0] SEL_STROBE_LAST = 5'h19;
    localparam logic [SEL_W-1:0] SEL_UNUSED_FIRST = 5'h1A;
    localparam logic [SEL_W-1:0] SEL_UNUSED_LAST = 5'h1D;
    localparam logic [SEL_W-1:0] SEL_OUT_BUFFER_ENABLE = 5'h1E;
    localparam logic [SEL_W-1:0] SEL_SOFTWARE_RESET = 5'h1F;
endpackage : pin_mux_pkg

//--- logic/pin_mux_top.sv
/*
 * Shared lock-detect / read-data pin with its observation mux, plus the
 * exact-frequency correction ratio, both reached through a serial register port.
 * Assumes serial pins are asynchronous to I_CLK and toggle well below I_CLK/4;
 * observation inputs come from logic on I_CLK.
 */
// What this block does
// (R1) Software loads ratio: comparison over correction rate.
// (R2) Ratio 0 or 1 disables exact mode.
// (R3) Pin tri-stated after reset, driven on reads.
// (R4) Always-on bit keeps driver on continuously.
// (R5) Host keeps line unshared while always-on set.
// (R6) Five-bit select picks pin signal, reset one.
// (R7) Select zero outputs software test bit.
// (R8) Codes route lock, slip and detector signals.
// (R9) Codes route reference, divider, clock, aux signals.
// (R10) Codes route strobes, buffer enable, soft reset.
// (R11) Inhibit bit stops muxing read data onto pin.
// (R12) Software keeps FET bits zero, avoids unused codes.
`timescale 1ns/1ps
`default_nettype none
module pin_mux_top (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // serial register port
    input wire logic I_SPI_SCK,
    input wire logic I_SPI_SEL_N,
    input wire logic I_SPI_SDI,
    // shared lock / read-data pin
    output logic O_LOCK_AND_READ_DATA_PIN,
    output logic O_LOCK_AND_READ_DATA_PIN_OE,
    // observation signals from the device core, indexed by select code
    input wire logic [pin_mux_pkg::OBS_W-1:0] I_OBS_SIGNALS,
    // register-driven controls
    output logic [pin_mux_pkg::RATIO_W-1:0] O_CORRECTION_RATIO,
    output logic O_EXACT_FREQ_ENABLE,
    output logic O_PULLUP_TRANSISTOR_OFF,
    output logic O_PULLDOWN_TRANSISTOR_OFF
);
    import pin_mux_pkg::*;

    // pin synchronisers
    logic sck_m_q, sck_s_q, sck_p_q;
    logic sel_m_q, sel_s_q;
    logic sdi_m_q, sdi_s_q;
    logic sck_rise, sck_fall;

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            sck_m_q <= 1'b0;
            sck_s_q <= 1'b0;
            sck_p_q <= 1'b0;
            sel_m_q <= 1'b1;
            sel_s_q <= 1'b1;
            sdi_m_q <= 1'b0;
            sdi_s_q <= 1'b0;
        end else begin
            sck_m_q <= I_SPI_SCK;
            sck_s_q <= sck_m_q;
            sck_p_q <= sck_s_q;
            sel_m_q <= I_SPI_SEL_N;
            sel_s_q <= sel_m_q;
            sdi_m_q <= I_SPI_SDI;
            sdi_s_q <= sdi_m_q;
        end
    end

    assign sck_rise = sck_s_q & ~sck_p_q;
    assign sck_fall = ~sck_s_q & sck_p_q;

    // serial frame state and registers
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [FRAME_BITS-2:0] shin_q, shin_d;
    logic [DATA_W-1:0] shout_q, shout_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic reading_q, reading_d;
    logic [RATIO_W-1:0] ratio_q, ratio_d;
    logic [PINSEL_W-1:0] pinsel_q, pinsel_d;
    logic [ADDR_W-1:0] hdr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] rd_value;

    assign hdr_addr = {shin_q[ADDR_W-2:0], sdi_s_q};
    assign wr_data = {shin_q[DATA_W-2:0], sdi_s_q};

    always_comb begin
        rd_value = '0;
        case (hdr_addr)
            EXACT_FREQUENCY_RATIO_OFS: rd_value[RATIO_W-1:0] = ratio_q;
            OUTPUT_PIN_SELECT_CONTROL_OFS: rd_value[PINSEL_W-1:0] = pinsel_q;
            default: rd_value = '0;
        endcase
    end

    always_comb begin
        cnt_d = cnt_q;
        shin_d = shin_q;
        shout_d = shout_q;
        addr_d = addr_q;
        reading_d = reading_q;
        ratio_d = ratio_q;
        pinsel_d = pinsel_q;
        if (sel_s_q) begin
            cnt_d = '0;
            reading_d = 1'b0;
        end else begin
            if (sck_rise) begin
                shin_d = {shin_q[FRAME_BITS-3:0], sdi_s_q};
                if (cnt_q != CNT_W'(FRAME_BITS)) begin
                    cnt_d = cnt_q + 1'b1;
                end
                if (cnt_q == CNT_W'(HDR_BITS - 1)) begin
                    addr_d = hdr_addr;
                    reading_d = shin_q[ADDR_W-1];
                    shout_d = rd_value;
                end
                if (cnt_q == CNT_W'(FRAME_BITS - 1) && !reading_q) begin
                    case (addr_q)
                        EXACT_FREQUENCY_RATIO_OFS: ratio_d = wr_data[RATIO_W-1:0]; // [R1]
                        OUTPUT_PIN_SELECT_CONTROL_OFS: pinsel_d = wr_data[PINSEL_W-1:0];
                        default: ;
                    endcase
                end
            end
            // first data bit is presented at header end; later bits on falling edges
            if (sck_fall && reading_q && cnt_q > CNT_W'(HDR_BITS)) begin
                shout_d = {shout_q[DATA_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            cnt_q <= '0;
            shin_q <= '0;
            shout_q <= '0;
            addr_q <= '0;
            reading_q <= 1'b0;
            ratio_q <= RATIO_RST;
            pinsel_q <= PINSEL_RST; // [R6]
        end else begin
            cnt_q <= cnt_d;
            shin_q <= shin_d;
            shout_q <= shout_d;
            addr_q <= addr_d;
            reading_q <= reading_d;
            ratio_q <= ratio_d;
            pinsel_q <= pinsel_d;
        end
    end

    // observation selection
    obs_sel_if sel_bus ();
    logic read_active;
    logic [OBS_W-1:0] obs_all;

    assign read_active = reading_q & ~sel_s_q;

    always_comb begin
        obs_all = I_OBS_SIGNALS;
        obs_all[SEL_LATCH_ENABLE] = ~sel_s_q; // [R10]
        obs_all[SEL_OUT_BUFFER_ENABLE] = O_LOCK_AND_READ_DATA_PIN_OE; // [R10]
    end

    assign sel_bus.sel = pinsel_q[SIGNAL_SELECT_LSB +: SEL_W];
    assign sel_bus.test_bit = pinsel_q[TEST_DATA_BIT];
    assign sel_bus.obs = obs_all;

    obs_selector u_obs_selector (
        .bus(sel_bus.chooser)
    );

    // pin drive and outputs
    logic pin_d, oe_d;
    logic exact_en_d;

    always_comb begin
        oe_d = pinsel_q[PIN_DRIVER_ALWAYS_ON_BIT] | read_active; // [R3] [R4]
        if (pinsel_q[AUTOMUX_INHIBIT_BIT]) begin
            pin_d = sel_bus.picked; // [R11]
        end else if (read_active) begin
            pin_d = shout_q[DATA_W-1]; // [R11]
        end else begin
            pin_d = sel_bus.picked; // [R11]
        end
        exact_en_d = (ratio_q >= RATIO_MIN_ACTIVE); // [R2]
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            O_LOCK_AND_READ_DATA_PIN <= 1'b0;
            O_LOCK_AND_READ_DATA_PIN_OE <= 1'b0; // [R3]
            O_CORRECTION_RATIO <= RATIO_RST;
            O_EXACT_FREQ_ENABLE <= 1'b0;
            O_PULLUP_TRANSISTOR_OFF <= 1'b0;
            O_PULLDOWN_TRANSISTOR_OFF <= 1'b0;
        end else begin
            O_LOCK_AND_READ_DATA_PIN <= pin_d;
            O_LOCK_AND_READ_DATA_PIN_OE <= oe_d;
            O_CORRECTION_RATIO <= ratio_q;
            O_EXACT_FREQ_ENABLE <= exact_en_d;
            O_PULLUP_TRANSISTOR_OFF <= pinsel_q[PULLUP_TRANSISTOR_OFF_BIT];
            O_PULLDOWN_TRANSISTOR_OFF <= pinsel_q[PULLDOWN_TRANSISTOR_OFF_BIT];
        end
    end
endmodule : pin_mux_top
`default_nettype wire

//--- tb/pin_mux_top_asserts.sv
/* pin mux port checker. assumes binding to pin_mux_top, one clock */
`timescale 1ns/1ps
`default_nettype none
module pin_mux_top_asserts (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_SPI_SCK,
    input wire logic I_SPI_SEL_N,
    input wire logic I_SPI_SDI,
    input wire logic O_LOCK_AND_READ_DATA_PIN,
    input wire logic O_LOCK_AND_READ_DATA_PIN_OE,
    input wire logic [pin_mux_pkg::OBS_W-1:0] I_OBS_SIGNALS,
    input wire logic [pin_mux_pkg::RATIO_W-1:0] O_CORRECTION_RATIO,
    input wire logic O_EXACT_FREQ_ENABLE,
    input wire logic O_PULLUP_TRANSISTOR_OFF,
    input wire logic O_PULLDOWN_TRANSISTOR_OFF
);
    import pin_mux_pkg::*;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    logic [3:0] idle_q;
    // cycles with no frame and quiet observation inputs
    always_ff @(posedge I_CLK) begin
        if (I_RST || !I_SPI_SEL_N || $changed(I_OBS_SIGNALS)) idle_q <= 4'h0;
        else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
    end
    logic sck_q, first_q, rd_frame_q;
    // read flag of the current frame, taken at its first clock rise
    always_ff @(posedge I_CLK) begin
        sck_q <= I_SPI_SCK;
        if (I_RST || I_SPI_SEL_N) begin
            first_q <= 1'b1;
            rd_frame_q <= 1'b0;
        end else if (I_SPI_SCK && !sck_q && first_q) begin
            first_q <= 1'b0;
            rd_frame_q <= I_SPI_SDI;
        end
    end
    property p_oe_rst; @(posedge I_CLK) $fell(I_RST) |-> !O_LOCK_AND_READ_DATA_PIN_OE; endproperty
    a_oe_rst: assert property (p_oe_rst) else $error("driver on after reset");
    property p_pin_rst; @(posedge I_CLK) $fell(I_RST) |-> !O_LOCK_AND_READ_DATA_PIN; endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin high after reset");
    property p_regs_rst;
        @(posedge I_CLK) $fell(I_RST) |-> O_CORRECTION_RATIO == 14'h0000 && !O_EXACT_FREQ_ENABLE
            && !O_PULLUP_TRANSISTOR_OFF && !O_PULLDOWN_TRANSISTOR_OFF;
    endproperty
    a_regs_rst: assert property (p_regs_rst) else $error("control outputs not cleared");
    property p_enable; $stable(O_CORRECTION_RATIO) [*3] |->
        O_EXACT_FREQ_ENABLE == (O_CORRECTION_RATIO > 14'h0001); endproperty
    a_enable: assert property (p_enable) else $error("exact mode enable mismatch");
    property p_oe_hold; rd_frame_q && O_LOCK_AND_READ_DATA_PIN_OE && !I_SPI_SEL_N
        |=> O_LOCK_AND_READ_DATA_PIN_OE;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("driver dropped in frame");
    property p_pin_idle; idle_q >= 4'hC |-> $stable(O_LOCK_AND_READ_DATA_PIN); endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("pin moved while idle");
    property p_oe_idle; idle_q >= 4'hC |-> $stable(O_LOCK_AND_READ_DATA_PIN_OE); endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("driver moved while idle");
    property p_regs_idle; idle_q >= 4'hC |-> $stable(O_CORRECTION_RATIO)
        && $stable(O_PULLUP_TRANSISTOR_OFF) && $stable(O_PULLDOWN_TRANSISTOR_OFF); endproperty
    a_regs_idle: assert property (p_regs_idle) else $error("register moved while idle");
endmodule : pin_mux_top_asserts
`default_nettype wire

//--- tb/spi_host_model.sv
/* serial host: 31-bit frames, msb first. assumes clk is the device clock */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model import pin_mux_pkg::*; (
    input wire logic clk,
    input wire logic line,
    output logic sck,
    output logic sel_n,
    output logic sdi
);
    localparam int HALF = 8;
    initial begin
        sck = 1'b0;
        sel_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic xfer(input logic rd, input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata);
        logic [FRAME_BITS-1:0] word;
        word = {rd, addr, wdata};
        rdata = '0;
        sel_n = 1'b0;
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            sdi = word[i];
            repeat (HALF) @(negedge clk);
            if (i < DATA_W) rdata[i] = line;
            sck = 1'b1;
            repeat (HALF) @(negedge clk);
            sck = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        sel_n = 1'b1;
        sdi = ~sdi;
        repeat (HALF) @(negedge clk);
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

//--- tb/test_pin_mux_top.sv
/* bench for pin_mux_top. assumes spi_host_model and the port checker */
`timescale 1ns/1ps
`default_nettype none
module test_pin_mux_top;
    import pin_mux_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sck, sel_n, sdi, pin, pin_oe, exact_en, pu_off, pd_off, line, last_q;
    int oe_cycles = 0;
    logic [OBS_W-1:0] obs = '0;
    logic [RATIO_W-1:0] ratio;
    logic [RATIO_W-1:0] ratios [5] = '{14'h0001, 14'h0000, 14'h0002, 14'h0055, 14'h3FFF};
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    // released line shows inverse of last driven value
    assign line = pin_oe ? pin : ~last_q;
    always @(posedge clk) begin
        cycles++;
        if (pin_oe) last_q <= pin;
        if (!sel_n && pin_oe) oe_cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            summarize();
        end
    end
    spi_host_model host (.clk(clk), .line(line), .sck(sck), .sel_n(sel_n), .sdi(sdi));
    pin_mux_top dut (.I_CLK(clk), .I_RST(rst), .I_SPI_SCK(sck), .I_SPI_SEL_N(sel_n),
        .I_SPI_SDI(sdi), .O_LOCK_AND_READ_DATA_PIN(pin), .O_LOCK_AND_READ_DATA_PIN_OE(pin_oe),
        .I_OBS_SIGNALS(obs), .O_CORRECTION_RATIO(ratio), .O_EXACT_FREQ_ENABLE(exact_en),
        .O_PULLUP_TRANSISTOR_OFF(pu_off), .O_PULLDOWN_TRANSISTOR_OFF(pd_off));
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        int oe_before;
        oe_before = oe_cycles;
        host.xfer(1'b1, a, '0, d);
        check(d, exp);
        check(24'(oe_cycles > oe_before), 24'h000001);
    endtask : rd
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] d;
        host.xfer(1'b0, a, v, d);
        repeat (3) @(negedge clk);
    endtask : wr
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        obs[1] = 1'b1;
        repeat (4) @(negedge clk);
        check(24'({pin_oe, pin}), 24'h000001);
        rd(OUTPUT_PIN_SELECT_CONTROL_OFS, 24'h000001);
        rd(EXACT_FREQUENCY_RATIO_OFS, 24'h000000);
        rd(6'h10, 24'h000000);
        foreach (ratios[k]) begin
            wr(EXACT_FREQUENCY_RATIO_OFS, {10'h3FF, ratios[k]});
            check(24'({exact_en, ratio}), 24'({ratios[k] > 14'h0001, ratios[k]}));
        end
        rd(EXACT_FREQUENCY_RATIO_OFS, 24'h003FFF);
        for (int c = 1; c < 32; c++) begin
            if (c inside {3, 7, [26:29]}) continue;
            wr(OUTPUT_PIN_SELECT_CONTROL_OFS, 24'h0000C0 | 24'(c));
            obs = ~(32'h1 << c);
            repeat (3) @(negedge clk);
            check(24'({pin_oe, pin}), 24'(c == 30 ? 3 : 2));
            obs = 32'h1 << c;
            repeat (3) @(negedge clk);
            check(24'({pin_oe, pin}), 24'(c == 23 ? 2 : 3));
        end
        wr(OUTPUT_PIN_SELECT_CONTROL_OFS, 24'h0000C0);
        check(24'(pin), 24'h000000);
        wr(OUTPUT_PIN_SELECT_CONTROL_OFS, 24'h0000E0);
        check(24'(pin), 24'h000001);
        rd(OUTPUT_PIN_SELECT_CONTROL_OFS, 24'hFFFFFF);
        wr(OUTPUT_PIN_SELECT_CONTROL_OFS, 24'h0000A0);
        rd(OUTPUT_PIN_SELECT_CONTROL_OFS, 24'h0000A0);
        wr(OUTPUT_PIN_SELECT_CONTROL_OFS, 24'hFFFF20);
        check(24'({pu_off, pd_off, pin_oe, pin}), 24'h00000D);
        rd(OUTPUT_PIN_SELECT_CONTROL_OFS, 24'h000320);
        summarize();
    end
endmodule : test_pin_mux_top
bind pin_mux_top pin_mux_top_asserts chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_SPI_SCK(I_SPI_SCK),
    .I_SPI_SEL_N(I_SPI_SEL_N), .I_SPI_SDI(I_SPI_SDI),
    .O_LOCK_AND_READ_DATA_PIN(O_LOCK_AND_READ_DATA_PIN),
    .O_LOCK_AND_READ_DATA_PIN_OE(O_LOCK_AND_READ_DATA_PIN_OE), .I_OBS_SIGNALS(I_OBS_SIGNALS),
    .O_CORRECTION_RATIO(O_CORRECTION_RATIO), .O_EXACT_FREQ_ENABLE(O_EXACT_FREQ_ENABLE),
    .O_PULLUP_TRANSISTOR_OFF(O_PULLUP_TRANSISTOR_OFF),
    .O_PULLDOWN_TRANSISTOR_OFF(O_PULLDOWN_TRANSISTOR_OFF));
`default_nettype wire
